/* rtl/bit_link_if.sv */
// filtered bus levels and line events passed from the filter to the core
`timescale 1ns/1ps
interface bit_link_if;
    logic scl;
    logic sda;
    logic pin_a;
    logic pin_b;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    modport front (output scl, sda, pin_a, pin_b, scl_rise, scl_fall, start_det, stop_det);
    modport core (input scl, sda, pin_a, pin_b, scl_rise, scl_fall, start_det, stop_det);
endinterface

/* rtl/expander_defines.svh */
// constants of the expander write path: addresses, byte fields, reset values
`ifndef EXPANDER_DEFINES_SVH
`define EXPANDER_DEFINES_SVH

// upper three slave-address bits per port group
`define GROUP_A_ADDR_HI 3'h6
`define GROUP_B_ADDR_HI 3'h5

// group A data byte layout
`define A_OUT0_BIT 0
`define A_OUT1_BIT 1
`define A_MASK_LSB 2
`define A_OUT6_BIT 6
`define A_OUT7_BIT 7

// reset values
`define OUT_RESET 1'b0
`define B_OUT_RESET 8'h00
`define MASK_RESET 4'h0
`define LINE_IDLE 4'hf

// bits per byte and the clock count that ends the byte
`define BYTE_BITS 4'h8

`endif

/* rtl/expander_pkg.sv */
// types of the expander write path
package expander_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_DATA,
        ST_DATA_ACK,
        ST_SKIP
    } xfer_state_t;

    // four-level strap code of one address-select pin
    typedef enum logic [1:0] {
        STRAP_GND,
        STRAP_SUPPLY,
        STRAP_DATA,
        STRAP_CLOCK
    } strap_t;
endpackage

/* rtl/i2c_expander_write_path.sv */
// serial-bus slave write path of the twelve-output port expander
`timescale 1ns/1ps
`include "expander_defines.svh"
// Function
// - acknowledge group A address, snapshot ports, release alert
// - each group A byte: acknowledge, outputs, mask
// - group B address acknowledged, ports sampled
// - each group B byte acknowledged, outputs updated
// - all bits of one byte change together
// - address prefix 110 group A, 101 group B
// - eighth bit low write, high read
// - two four-level pins give low address bits
module i2c_expander_write_path
    import expander_pkg::*;
#(
    parameter int MON_W = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic scl_pin,
    input wire logic sda_pin,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_select_pin_a,
    input wire logic addr_select_pin_b,
    input wire logic [MON_W-1:0] monitored_inputs,
    output logic group_a_output_0,
    output logic group_a_output_1,
    output logic group_a_output_6,
    output logic group_a_output_7,
    output logic [7:0] group_b_outputs,
    output logic [MON_W-1:0] int_mask,
    output logic [7:0] port_snapshot,
    output logic snapshot_strobe,
    output logic alert_release
);
    if (MON_W != 4) begin : g_bad_width
        $error("group A byte carries exactly four monitored inputs");
    end

    bit_link_if lk ();

    i2c_line_filter #(.LINES(4)) u_filter (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .scl_pin(scl_pin),
        .sda_pin(sda_pin),
        .pin_a(addr_select_pin_a),
        .pin_b(addr_select_pin_b),
        .lk(lk)
    );

    // ****************************************
    // decode helpers
    // ****************************************
    // s: pin with data low and clock high; p: pin with data high and clock low
    function automatic strap_t strap_code(input logic s, input logic p);
        case ({s, p})
            2'b00: strap_code = STRAP_GND;
            2'b11: strap_code = STRAP_SUPPLY;
            2'b01: strap_code = STRAP_DATA;
            default: strap_code = STRAP_CLOCK;
        endcase
    endfunction

    function automatic logic addr_match(input logic [7:0] b, input logic [2:0] hi,
                                        input logic [3:0] lo);
        addr_match = (b[7:5] == hi) && (b[4:1] == lo) && !b[0];
    endfunction

    // ****************************************
    // transfer state
    // ****************************************
    xfer_state_t state_reg, state_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next;
    logic group_b_reg, group_b_next;
    logic [1:0] strap_s_reg, strap_s_next;
    logic [1:0] pin_prev_reg;
    logic [3:0] addr_low_reg, addr_low_next;
    logic oe_reg, oe_next;
    logic a0_reg, a0_next, a1_reg, a1_next, a6_reg, a6_next, a7_reg, a7_next;
    logic [7:0] b_reg, b_next;
    logic [MON_W-1:0] mask_reg, mask_next;
    logic [7:0] snap_reg, snap_next;
    logic snap_stb_reg, snap_stb_next;
    logic rel_reg, rel_next;
    logic [MON_W-1:0] mon_s1_reg, mon_s2_reg, mon_s3_reg, mon_reg, mon_next; // async pins

    // start and stop win over any byte in flight, so a cut byte is dropped
    always_comb begin
        state_next = state_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        group_b_next = group_b_reg;
        strap_s_next = strap_s_reg;
        addr_low_next = addr_low_reg;
        oe_next = oe_reg;
        a0_next = a0_reg;
        a1_next = a1_reg;
        a6_next = a6_reg;
        a7_next = a7_reg;
        b_next = b_reg;
        mask_next = mask_reg;
        snap_next = snap_reg;
        snap_stb_next = 1'b0;
        rel_next = 1'b0;
        mon_next = (mon_s2_reg & mon_s3_reg) | (mon_reg & (mon_s2_reg | mon_s3_reg));
        if (lk.start_det) begin
            state_next = ST_ADDR;
            bit_next = 4'h0;
            oe_next = 1'b0;
            strap_s_next = {lk.pin_b, lk.pin_a}; // data low, clock high
        end else if (lk.stop_det) begin
            state_next = ST_IDLE;
            oe_next = 1'b0;
        end else begin
            case (state_reg)
                ST_ADDR: begin
                    if (lk.scl_rise) begin
                        shift_next = {shift_reg[6:0], lk.sda};
                        bit_next = bit_reg + 4'h1;
                        // first bit is always high, clock was low a cycle ago
                        if (bit_reg == 4'h0) begin
                            addr_low_next = {strap_code(strap_s_reg[1], pin_prev_reg[1]),
                                             strap_code(strap_s_reg[0], pin_prev_reg[0])};
                        end
                    end else if (lk.scl_fall && bit_reg == `BYTE_BITS) begin
                        // reads belong to the read path, so they are not answered here
                        if (addr_match(shift_reg, `GROUP_A_ADDR_HI, addr_low_reg)) begin
                            group_b_next = 1'b0;
                            oe_next = 1'b1;
                            state_next = ST_ADDR_ACK;
                        end else if (addr_match(shift_reg, `GROUP_B_ADDR_HI, addr_low_reg)) begin
                            group_b_next = 1'b1;
                            oe_next = 1'b1;
                            state_next = ST_ADDR_ACK;
                        end else begin
                            state_next = ST_SKIP;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (lk.scl_rise) begin
                        snap_stb_next = 1'b1;
                        rel_next = !group_b_reg;
                        snap_next = group_b_reg ? b_reg :
                            {a7_reg, a6_reg, mon_reg, a1_reg, a0_reg};
                    end else if (lk.scl_fall) begin
                        oe_next = 1'b0;
                        bit_next = 4'h0;
                        state_next = ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (lk.scl_rise) begin
                        shift_next = {shift_reg[6:0], lk.sda};
                        bit_next = bit_reg + 4'h1;
                    end else if (lk.scl_fall && bit_reg == `BYTE_BITS) begin
                        oe_next = 1'b1;
                        state_next = ST_DATA_ACK;
                    end
                end
                ST_DATA_ACK: begin
                    // whole byte lands on one edge after its acknowledge
                    if (lk.scl_fall) begin
                        oe_next = 1'b0;
                        bit_next = 4'h0;
                        state_next = ST_DATA;
                        if (group_b_reg) begin
                            b_next = shift_reg;
                        end else begin
                            a0_next = shift_reg[`A_OUT0_BIT];
                            a1_next = shift_reg[`A_OUT1_BIT];
                            a6_next = shift_reg[`A_OUT6_BIT];
                            a7_next = shift_reg[`A_OUT7_BIT];
                            mask_next = shift_reg[`A_MASK_LSB +: MON_W];
                        end
                    end
                end
                ST_IDLE, ST_SKIP: begin
                    oe_next = 1'b0;
                end
                default: begin
                    state_next = ST_IDLE;
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            bit_reg <= 4'h0;
            shift_reg <= 8'h00;
            group_b_reg <= 1'b0;
            strap_s_reg <= 2'h0;
            pin_prev_reg <= 2'h0;
            addr_low_reg <= 4'h0;
            oe_reg <= 1'b0;
            a0_reg <= `OUT_RESET;
            a1_reg <= `OUT_RESET;
            a6_reg <= `OUT_RESET;
            a7_reg <= `OUT_RESET;
            b_reg <= `B_OUT_RESET;
            mask_reg <= `MASK_RESET;
            snap_reg <= 8'h00;
            snap_stb_reg <= 1'b0;
            rel_reg <= 1'b0;
            mon_s1_reg <= {MON_W{1'b0}};
            mon_s2_reg <= {MON_W{1'b0}};
            mon_s3_reg <= {MON_W{1'b0}};
            mon_reg <= {MON_W{1'b0}};
        end else begin
            state_reg <= state_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            group_b_reg <= group_b_next;
            strap_s_reg <= strap_s_next;
            pin_prev_reg <= {lk.pin_b, lk.pin_a};
            addr_low_reg <= addr_low_next;
            oe_reg <= oe_next;
            a0_reg <= a0_next;
            a1_reg <= a1_next;
            a6_reg <= a6_next;
            a7_reg <= a7_next;
            b_reg <= b_next;
            mask_reg <= mask_next;
            snap_reg <= snap_next;
            snap_stb_reg <= snap_stb_next;
            rel_reg <= rel_next;
            mon_s1_reg <= monitored_inputs;
            mon_s2_reg <= mon_s1_reg;
            mon_s3_reg <= mon_s2_reg;
            mon_reg <= mon_next;
        end
    end

    // open drain: the pin is only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe = oe_reg;
    assign group_a_output_0 = a0_reg;
    assign group_a_output_1 = a1_reg;
    assign group_a_output_6 = a6_reg;
    assign group_a_output_7 = a7_reg;
    assign group_b_outputs = b_reg;
    assign int_mask = mask_reg;
    assign port_snapshot = snap_reg;
    assign snapshot_strobe = snap_stb_reg;
    assign alert_release = rel_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence addr_done_s;
        state_reg == ST_ADDR && lk.scl_fall && bit_reg == `BYTE_BITS
            && !lk.start_det && !lk.stop_det;
    endsequence

    sequence data_done_s;
        state_reg == ST_DATA && lk.scl_fall && bit_reg == `BYTE_BITS
            && !lk.start_det && !lk.stop_det;
    endsequence

    addr_write_only_a: assert property (addr_done_s ##1 oe_reg |-> !$past(shift_reg[0]))
        else $error("address acknowledged for a read");
    addr_prefix_a: assert property (addr_done_s ##1 oe_reg |->
        $past(shift_reg[7:5]) == `GROUP_A_ADDR_HI || $past(shift_reg[7:5]) == `GROUP_B_ADDR_HI)
        else $error("address acknowledged with a foreign prefix");
    addr_low_bits_a: assert property (state_reg == ST_ADDR_ACK |-> shift_reg[4:1] == addr_low_reg)
        else $error("low address bits differ from strap code");
    snap_in_ack_a: assert property (snap_stb_reg |-> $past(state_reg) == ST_ADDR_ACK && oe_reg)
        else $error("snapshot outside address acknowledge");
    alert_group_a: assert property (rel_reg |-> snap_stb_reg && !group_b_reg)
        else $error("alert release without group A snapshot");
    data_ack_a: assert property (data_done_s |=> oe_reg && state_reg == ST_DATA_ACK ##1
        (oe_reg && state_reg == ST_DATA_ACK) [*1])
        else $error("data byte not acknowledged");
    b_update_a: assert property ($changed(b_reg) |->
        $past(state_reg) == ST_DATA_ACK && $past(lk.scl_fall) && group_b_reg)
        else $error("group B outputs moved outside a completed byte");
    mask_update_a: assert property ($changed(mask_reg) || $changed(a0_reg) |->
        $past(state_reg) == ST_DATA_ACK && $past(lk.scl_fall) && !group_b_reg)
        else $error("group A state moved outside a completed byte");
    stop_idle_a: assert property (lk.stop_det && !lk.start_det |=> state_reg == ST_IDLE && !oe_reg)
        else $error("stop did not end the transfer");
endmodule

/* rtl/i2c_line_filter.sv */
// pin synchroniser, glitch filter and start/stop/edge detection
`timescale 1ns/1ps
`include "expander_defines.svh"
module i2c_line_filter #(
    parameter int LINES = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic scl_pin,
    input wire logic sda_pin,
    input wire logic pin_a,
    input wire logic pin_b,
    bit_link_if.front lk
);
    if (LINES != 4) begin : g_bad_lines
        $error("line filter serves exactly four lines");
    end

    // ****************************************
    // three-stage synchroniser and filter
    // ****************************************
    logic [LINES-1:0] raw;
    logic [LINES-1:0] s1_reg, s2_reg, s3_reg;
    logic [LINES-1:0] lvl_reg, lvl_next;
    logic rise_reg, rise_next, fall_reg, fall_next;
    logic start_reg, start_next, stop_reg, stop_next;

    assign raw = {pin_b, pin_a, sda_pin, scl_pin};

    // a level only moves once stages two and three agree
    for (genvar i = 0; i < LINES; i++) begin : g_filt
        always_comb begin
            lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s2_reg[i] : lvl_reg[i];
        end
    end

    // events taken from filtered levels, never from the first stage
    always_comb begin
        rise_next = lvl_next[0] & ~lvl_reg[0];
        fall_next = ~lvl_next[0] & lvl_reg[0];
        start_next = lvl_reg[0] & lvl_next[0] & lvl_reg[1] & ~lvl_next[1];
        stop_next = lvl_reg[0] & lvl_next[0] & ~lvl_reg[1] & lvl_next[1];
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= `LINE_IDLE;
            s2_reg <= `LINE_IDLE;
            s3_reg <= `LINE_IDLE;
            lvl_reg <= `LINE_IDLE;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
            start_reg <= 1'b0;
            stop_reg <= 1'b0;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
            start_reg <= start_next;
            stop_reg <= stop_next;
        end
    end

    assign lk.scl = lvl_reg[0];
    assign lk.sda = lvl_reg[1];
    assign lk.pin_a = lvl_reg[2];
    assign lk.pin_b = lvl_reg[3];
    assign lk.scl_rise = rise_reg;
    assign lk.scl_fall = fall_reg;
    assign lk.start_det = start_reg;
    assign lk.stop_det = stop_reg;
endmodule

/* verification/i2c_master_model.sv */
// behavioural serial-bus master that drives the expander's clock and data pins
`timescale 1ns/1ps
module i2c_master_model #(
    parameter int QTR = 4
) (
    input wire logic core_clk,
    input wire logic sda_line,
    output logic scl_drv,
    output logic sda_drv
);
    // idle bus: both lines released high
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end

    // ****************************************
    // bus phases, all moved on core_clk edges
    // ****************************************
    // quarter bit; phases kept above the filter's minimum, hence 400 ns per bit
    task automatic q(input int n);
        repeat (n * QTR) @(posedge core_clk);
    endtask

    task automatic start();
        sda_drv <= 1'b0;
        q(2);
        scl_drv <= 1'b0;
        q(1);
    endtask

    // data only changes while the clock is low
    task automatic send_bit(input logic b);
        sda_drv <= b;
        q(1);
        scl_drv <= 1'b1;
        q(2);
        scl_drv <= 1'b0;
        q(1);
    endtask

    // msb first, then a released ninth clock that samples the acknowledge
    task automatic send_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            send_bit(d[i]);
        end
        sda_drv <= 1'b1;
        q(1);
        scl_drv <= 1'b1;
        q(1);
        ack = ~sda_line;
        q(1);
        scl_drv <= 1'b0;
        q(1);
    endtask

    // a byte cut short: only the leading bits go out
    task automatic send_bits(input logic [7:0] d, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            send_bit(d[i]);
        end
    endtask

    // repeated start from a low clock: release data, raise the clock, then start
    task automatic restart();
        sda_drv <= 1'b1;
        q(1);
        scl_drv <= 1'b1;
        q(1);
        start();
    endtask

    task automatic stop();
        sda_drv <= 1'b0;
        q(1);
        scl_drv <= 1'b1;
        q(2);
        sda_drv <= 1'b1;
        q(2);
    endtask
endmodule

/* verification/tb.sv */
// self-checking bench for the expander write path
`timescale 1ns/1ps
module tb;
    import expander_pkg::*;
    typedef struct packed {
        logic [1:0] sb;
        logic [1:0] sa;
        logic grp;
        logic [3:0] mon;
        logic [7:0] d0;
        logic [7:0] d1;
    } row_t;
    logic core_clk, rst_n, sda_out, sda_oe, scl_drv, sda_drv, ack;
    logic a0, a1, a6, a7, snap_stb, alert;
    logic [1:0] code_a, code_b;
    logic [3:0] mon, mask;
    logic [7:0] b_out, snap, exp_a, exp_b;
    wire sda_line = sda_drv & ~(sda_oe & ~sda_out);
    int fails, n_checks, n_snap, n_alert, s0, a_0;
    row_t rows [4];

    // strap pin tied to ground, supply, data or clock
    function automatic logic strap(input logic [1:0] c, input logic sc, input logic sd);
        return (c == 2'h0) ? 1'b0 : (c == 2'h1) ? 1'b1 : (c == 2'h2) ? sd : sc;
    endfunction

    i2c_expander_write_path i2c_expander_write_path_i (
        .core_clk(core_clk), .rst_n(rst_n), .scl_pin(scl_drv), .sda_pin(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_select_pin_a(strap(code_a, scl_drv, sda_line)),
        .addr_select_pin_b(strap(code_b, scl_drv, sda_line)),
        .monitored_inputs(mon), .group_a_output_0(a0), .group_a_output_1(a1),
        .group_a_output_6(a6), .group_a_output_7(a7), .group_b_outputs(b_out),
        .int_mask(mask), .port_snapshot(snap), .snapshot_strobe(snap_stb),
        .alert_release(alert)
    );
    i2c_master_model master_i (
        .core_clk(core_clk), .sda_line(sda_line), .scl_drv(scl_drv), .sda_drv(sda_drv)
    );

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // one-cycle strobes are counted, not sampled by chance
    always @(posedge core_clk) begin
        n_snap <= n_snap + int'(snap_stb === 1'b1);
        n_alert <= n_alert + int'(alert === 1'b1);
    end

    // ************
    // compare tasks
    // ************
    task automatic chk1(input string what, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_out();
        chk8("group a image", exp_a, {a7, a6, mask, a1, a0});
        chk8("group b outputs", exp_b, b_out);
    endtask

    task automatic addr(input logic [6:0] a, input logic rw, input logic e);
        s0 = n_snap;
        a_0 = n_alert;
        master_i.start();
        master_i.send_byte({a, rw}, ack);
        chk1("address ack", e, ack);
        chk1("snapshot strobe", e, n_snap == s0 + 1);
    endtask

    // writes land only after the ack clock ends, so let the filter lag pass
    task automatic wr(input logic [7:0] d, input logic grp);
        master_i.send_byte(d, ack);
        chk1("data ack", 1'b1, ack);
        repeat (8) @(posedge core_clk);
        if (grp) exp_b = d;
        else exp_a = d;
        chk_out();
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog well beyond the roughly 3500 cycles of traffic
    initial begin
        repeat (60000) @(posedge core_clk);
        fails++;
        report_and_stop();
    end

    // ************
    // main sequence
    // ************
    initial begin
        rst_n = 1'b0;
        mon = 4'h0;
        code_a = 2'h0;
        code_b = 2'h0;
        exp_a = 8'h00;
        exp_b = 8'h00;
        rows[0] = '{2'h0, 2'h1, 1'b0, 4'ha, 8'h55, 8'haa};
        rows[1] = '{2'h1, 2'h2, 1'b1, 4'h5, 8'hff, 8'h00};
        rows[2] = '{2'h2, 2'h3, 1'b0, 4'h3, 8'hc3, 8'h3c};
        rows[3] = '{2'h3, 2'h0, 1'b1, 4'hc, 8'h81, 8'h7e};
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chk_out();
        chk1("ack drive idle", 1'b0, sda_oe);
        repeat (8) @(posedge core_clk);
        foreach (rows[i]) begin
            code_a <= rows[i].sa;
            code_b <= rows[i].sb;
            mon <= rows[i].mon;
            @(posedge core_clk);
            addr({rows[i].grp ? 3'h5 : 3'h6, rows[i].sb, rows[i].sa}, 1'b0, 1'b1);
            chk8("snapshot", rows[i].grp ? exp_b : {exp_a[7:6], rows[i].mon, exp_a[1:0]},
                snap);
            chk1("alert release", !rows[i].grp, n_alert == a_0 + 1);
            wr(rows[i].d0, rows[i].grp);
            wr(rows[i].d1, rows[i].grp);
            master_i.stop();
        end
        // refused addresses leave everything alone; straps now scl and ground
        addr(7'h70, 1'b0, 1'b0);
        master_i.stop();
        addr(7'h65, 1'b0, 1'b0);
        master_i.stop();
        addr(7'h6c, 1'b1, 1'b0);
        master_i.stop();
        chk_out();
        // address then stop at once: alert released, outputs kept
        addr(7'h6c, 1'b0, 1'b1);
        master_i.stop();
        chk1("alert on bare address", 1'b1, n_alert == a_0 + 1);
        chk_out();
        // byte cut by stop after five bits changes nothing
        addr(7'h5c, 1'b0, 1'b1);
        master_i.send_bits(8'h0f, 5);
        master_i.stop();
        chk_out();
        // byte cut by a repeated start is dropped, the next address and byte still land
        addr(7'h5c, 1'b0, 1'b1);
        master_i.send_bits(8'h0f, 6);
        master_i.restart();
        master_i.send_byte({7'h5c, 1'b0}, ack);
        chk1("ack after restart", 1'b1, ack);
        chk_out();
        wr(8'h96, 1'b1);
        // reset in mid-byte returns every output to its reset level
        master_i.send_bits(8'h00, 3);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        exp_a = 8'h00;
        exp_b = 8'h00;
        @(posedge core_clk);
        chk_out();
        chk1("ack drive after reset", 1'b0, sda_oe);
        master_i.stop();
        chk1("ack drive released", 1'b0, sda_oe);
        report_and_stop();
    end
endmodule
